// *** common/ccs_pkg.sv ***
package ccs_pkg;
    // Register indexes; byte address is four times the index
    localparam logic [15:0] IDX_SLEW   = 16'h1c16;
    localparam logic [15:0] IDX_SRC    = 16'h1c20;
    localparam logic [15:0] IDX_ST3    = 16'h1c21;
    localparam logic [15:0] IDX_CLKGEN = 16'h1c22;
    localparam logic [15:0] IDX_STATUS = 16'h1c23;
    localparam int ADDR_W = 18;
    localparam logic [17:0] ADDR_SLEW   = {IDX_SLEW, 2'b00};
    localparam logic [17:0] ADDR_SRC    = {IDX_SRC, 2'b00};
    localparam logic [17:0] ADDR_ST3    = {IDX_ST3, 2'b00};
    localparam logic [17:0] ADDR_CLKGEN = {IDX_CLKGEN, 2'b00};
    localparam logic [17:0] ADDR_STATUS = {IDX_STATUS, 2'b00};

    // Field positions
    localparam int SRC_LSB    = 0;
    localparam int DIS_BIT    = 2;
    localparam int BYP_BIT    = 0;
    localparam int REFSEL_LSB = 1;
    localparam int MULT_LSB   = 4;
    localparam int MULT_W     = 12;

    typedef enum logic [1:0] {
        SRC_PLL  = 2'b00,
        SRC_REF  = 2'b01,
        SRC_OSC  = 2'b10,
        SRC_DIV2 = 2'b11
    } ccs_src_t;

    // Reset values
    localparam ccs_src_t    SRC_RST    = SRC_PLL;
    localparam logic        DIS_RST    = 1'b0;
    localparam logic        BYP_RST    = 1'b1;
    localparam logic [1:0]  REFSEL_RST = 2'h0;
    localparam logic [11:0] MULT_RST   = 12'h001;
    localparam logic [15:0] SLEW_RST   = 16'h0000;

    // Frequencies in Hz
    localparam int unsigned OSC_HZ     = 32768;
    localparam int unsigned REF0_HZ    = 11289600;
    localparam int unsigned REF1_HZ    = 12000000;
    localparam int unsigned REF2_HZ    = 12288000;
    localparam int unsigned PLL_MAX_HZ = 120000000;
    localparam int unsigned SPI_HZ     = 500000;
    localparam int unsigned I2C_HZ     = 400000;

    // Serial clock divisors, rounded up so rates never exceed target
    localparam logic [7:0] SPI_DIV_0 = 8'((REF0_HZ + SPI_HZ - 1) / SPI_HZ);
    localparam logic [7:0] SPI_DIV_1 = 8'((REF1_HZ + SPI_HZ - 1) / SPI_HZ);
    localparam logic [7:0] SPI_DIV_2 = 8'((REF2_HZ + SPI_HZ - 1) / SPI_HZ);
    localparam logic [7:0] I2C_DIV_0 = 8'((REF0_HZ + I2C_HZ - 1) / I2C_HZ);
    localparam logic [7:0] I2C_DIV_1 = 8'((REF1_HZ + I2C_HZ - 1) / I2C_HZ);
    localparam logic [7:0] I2C_DIV_2 = 8'((REF2_HZ + I2C_HZ - 1) / I2C_HZ);
    localparam logic [7:0] DIV_MIN   = 8'h01;
endpackage : ccs_pkg

// *** hdl/ccs_clock_select.sv ***
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
// How it works
// - Debug clock pin carries the internal clock picked by the source field
// - Disable bit in status register 3 tri-states the debug clock pin
// - Debug clock pin is enabled after reset until boot sets the disable bit
// - Strap low: oscillator drives timer and clock generator, external input ignored
// - Strap high: external input feeds generator, oscillator drives only timer
// - External reference mode boots with the PLL bypassed at assumed frequencies
// - Strap high: serial clock dividers follow assumed reference (500 kHz, 400 kHz); strap low holds them at 1
// - PLL output frequency never exceeds 120 MHz
module ccs_clock_select
    import ccs_pkg::*;
(
    input  wire logic              sys_clk,            // System clock, 40 MHz
    input  wire logic              rst,                // Synchronous reset
    input  wire logic              clock_src_strap,    // Board clock source strap
    input  wire logic              osc_32k_in,         // On-chip oscillator level
    input  wire logic              ext_clock_in,       // External clock level
    input  wire logic              pll_output_clock,   // PLL output level
    input  wire logic              psel,               // APB select
    input  wire logic              penable,            // APB enable
    input  wire logic              pwrite,             // APB write
    input  wire logic [ADDR_W-1:0] paddr,              // APB byte address
    input  wire logic [31:0]       pwdata,             // APB write data
    output logic [31:0]            prdata,             // APB read data
    output logic                   pready,             // APB ready
    output logic                   pslverr,            // APB error
    output logic                   debug_clock_out,    // Debug clock pin value
    output logic                   debug_clock_out_oe, // Debug clock pin enable
    output logic                   sys_ref_clock,      // Generator reference
    output logic                   rtc_clock,          // Timer clock
    output logic                   pll_bypass,         // PLL bypass control
    output logic [MULT_W-1:0]      pll_mult,           // PLL multiplier
    output logic [7:0]             spi_clk_div,        // Serial interface divider
    output logic [7:0]             i2c_clk_div,        // Two-wire bus divider
    output logic [15:0]            slew_ctrl           // Output slew control
);

    ccs_src_t    clock_out_source_sel;
    ccs_src_t    active_sel;
    logic        clock_out_disable;
    logic [1:0]  ref_sel;
    logic        strap_q;
    logic        div2_q;
    logic [3:0]  src_vec;
    logic        cur_src;
    logic        new_src;
    logic        access;
    logic        wr_en;
    logic        addr_ok;
    logic [31:0] next_rdata;
    logic [31:0] ref_hz;
    logic [31:0] next_ref_hz;
    logic [1:0]  new_ref_sel;
    logic [11:0] new_mult;
    logic [43:0] new_prod;
    logic        mult_ok;

    // Reference frequency assumed for a given selection
    function automatic logic [31:0] ref_lut(input logic strap, input logic [1:0] sel);
        logic [31:0] f;
        f = OSC_HZ;
        if (strap) begin
            case (sel)
                2'h0:    f = REF0_HZ;
                2'h1:    f = REF1_HZ;
                default: f = REF2_HZ;
            endcase
        end
        return f;
    endfunction : ref_lut

    // ---------------- Strap and reference routing ----------------
    // Strap caught during reset; the board keeps it fixed afterwards
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            strap_q <= clock_src_strap;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sys_ref_clock <= 1'b0;
            rtc_clock     <= 1'b0;
        end else begin
            rtc_clock <= osc_32k_in;
            if (strap_q) begin
                sys_ref_clock <= ext_clock_in;
            end else begin
                sys_ref_clock <= osc_32k_in;
            end
        end
    end

    // ---------------- Debug clock source mux ----------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            div2_q <= 1'b0;
        end else begin
            div2_q <= ~div2_q;
        end
    end

    always_comb begin
        src_vec          = '0;
        src_vec[SRC_PLL]  = pll_output_clock;
        src_vec[SRC_REF]  = sys_ref_clock;
        src_vec[SRC_OSC]  = osc_32k_in;
        src_vec[SRC_DIV2] = div2_q;
        cur_src          = src_vec[active_sel];
        new_src          = src_vec[clock_out_source_sel];
    end

    // Switch only while old and new source are both low
    // Old high phase has ended, new one starts whole
    // Not gated on the pin: a source toggling every cycle would lock
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_sel <= SRC_RST;
        end else if (active_sel != clock_out_source_sel
                     && !cur_src && !new_src) begin
            active_sel <= clock_out_source_sel;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            debug_clock_out <= 1'b0;
        end else begin
            debug_clock_out <= cur_src;
        end
    end

    // Enable changes only while the next pin value is low
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            debug_clock_out_oe <= 1'b1;
        end else if (!cur_src) begin
            debug_clock_out_oe <= ~clock_out_disable;
        end
    end

    // ---------------- APB slave ----------------
    assign access = psel && penable;
    assign wr_en  = access && pready && pwrite && addr_ok;

    always_comb begin
        addr_ok    = 1'b1;
        next_rdata = '0;
        case (paddr)
            ADDR_SLEW:   next_rdata[15:0] = slew_ctrl;
            ADDR_SRC:    next_rdata[SRC_LSB +: 2] = clock_out_source_sel;
            ADDR_ST3:    next_rdata[DIS_BIT] = clock_out_disable;
            ADDR_CLKGEN: begin
                next_rdata[BYP_BIT] = pll_bypass;
                next_rdata[REFSEL_LSB +: 2] = ref_sel;
                next_rdata[MULT_LSB +: MULT_W] = pll_mult;
            end
            ADDR_STATUS: next_rdata = {28'h0, active_sel,
                                       debug_clock_out_oe, strap_q};
            default:     addr_ok = 1'b0;
        endcase
    end

    // Access phase lasts two cycles; ready and data come from flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !addr_ok;
            if (access && !pready && !pwrite) begin
                prdata <= next_rdata;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            slew_ctrl <= SLEW_RST;
        end else if (wr_en && paddr == ADDR_SLEW) begin
            slew_ctrl <= pwdata[15:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clock_out_source_sel <= SRC_RST;
        end else if (wr_en && paddr == ADDR_SRC) begin
            clock_out_source_sel <= ccs_src_t'(pwdata[SRC_LSB +: 2]);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clock_out_disable <= DIS_RST;
        end else if (wr_en && paddr == ADDR_ST3) begin
            clock_out_disable <= pwdata[DIS_BIT];
        end
    end

    // ---------------- Clock generator settings ----------------
    assign new_ref_sel = pwdata[REFSEL_LSB +: 2];
    assign new_mult    = pwdata[MULT_LSB +: MULT_W];
    assign next_ref_hz = ref_lut(strap_q, new_ref_sel);
    assign ref_hz      = ref_lut(strap_q, ref_sel);
    assign new_prod    = 44'(next_ref_hz) * 44'(new_mult);
    assign mult_ok     = (new_mult != '0) && (new_prod <= 44'(PLL_MAX_HZ));

    // A setting that would overclock the PLL is ignored whole
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pll_bypass <= BYP_RST;
            ref_sel    <= REFSEL_RST;
            pll_mult   <= MULT_RST;
        end else if (wr_en && paddr == ADDR_CLKGEN && mult_ok) begin
            pll_bypass <= pwdata[BYP_BIT];
            ref_sel    <= new_ref_sel;
            pll_mult   <= new_mult;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            spi_clk_div <= DIV_MIN;
            i2c_clk_div <= DIV_MIN;
        end else if (!strap_q) begin
            spi_clk_div <= DIV_MIN;
            i2c_clk_div <= DIV_MIN;
        end else begin
            case (ref_sel)
                2'h0: begin
                    spi_clk_div <= SPI_DIV_0;
                    i2c_clk_div <= I2C_DIV_0;
                end
                2'h1: begin
                    spi_clk_div <= SPI_DIV_1;
                    i2c_clk_div <= I2C_DIV_1;
                end
                default: begin
                    spi_clk_div <= SPI_DIV_2;
                    i2c_clk_div <= I2C_DIV_2;
                end
            endcase
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_SRC_ROUTE: assert property (
        (active_sel == clock_out_source_sel)
        |=> debug_clock_out == $past(new_src))
        else $error("debug clock does not follow selected source");

    AST_OE_OFF: assert property (
        (clock_out_disable && !cur_src)
        |=> !debug_clock_out_oe)
        else $error("debug clock pin not tri-stated when disabled");

    AST_OE_ON: assert property (
        (!clock_out_disable && !cur_src)
        |=> debug_clock_out_oe)
        else $error("debug clock pin not enabled");

    AST_RESET_EN: assert property (
        $fell(rst) |-> debug_clock_out_oe && !clock_out_disable && pll_bypass)
        else $error("debug clock pin not enabled after reset");

    AST_OSC_ONLY: assert property (
        !strap_q |=> sys_ref_clock == $past(osc_32k_in))
        else $error("oscillator mode reference wrong");

    AST_EXT_REF: assert property (
        strap_q |=> sys_ref_clock == $past(ext_clock_in)
                    && rtc_clock == $past(osc_32k_in))
        else $error("external mode reference wrong");

    AST_DIVS: assert property (
        (strap_q && ref_sel == 2'h1) |=> spi_clk_div == SPI_DIV_1
                                         && i2c_clk_div == I2C_DIV_1)
        else $error("serial divider mismatch");

    AST_PLL_MAX: assert property (
        !$rose(rst) |-> 44'(ref_hz) * 44'(pll_mult) <= 44'(PLL_MAX_HZ))
        else $error("PLL frequency above limit");

    AST_NO_GLITCH: assert property (
        $changed(active_sel) |-> !debug_clock_out && !$past(new_src))
        else $error("source switched during high phase");

    AST_OE_LOW: assert property (
        $changed(debug_clock_out_oe) |-> !debug_clock_out)
        else $error("enable changed during high phase");

endmodule : ccs_clock_select

// *** verif/ccs_board_model.sv ***
`timescale 1ns/1ps
// Board side: fixed strap, scaled-down oscillator (period of ten sys_clk cycles), external clock and PLL levels
module ccs_board_model (
    input  wire logic sys_clk,          // System clock
    input  wire logic strap_sel,        // Strap level chosen at power-up
    output logic      clock_src_strap,  // Strap pin
    output logic      osc_32k_in,       // Scaled-down oscillator level
    output logic      ext_clock_in,     // External clock level
    output logic      pll_output_clock  // PLL output level
);
    logic [3:0] cnt = 4'h0;
    initial begin
        osc_32k_in = 1'b0;
        ext_clock_in = 1'b0;
        pll_output_clock = 1'b0;
    end
    assign clock_src_strap = strap_sel;
    always @(posedge sys_clk) begin
        cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
        if (cnt == 4'h4 || cnt == 4'h9) begin
            osc_32k_in <= ~osc_32k_in;
        end
        ext_clock_in <= strap_sel & ~cnt[0];
        pll_output_clock <= cnt[1];
    end
endmodule : ccs_board_model

// *** verif/tb.sv ***
`timescale 1ns/1ps
module tb;
    import ccs_pkg::*;
    logic sys_clk, rst, strap, psel, penable, pwrite, trk;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, err, dbg, oe, ref_clk, rtc, byp, osc, ext, pll, strap_pin;
    logic p_osc, p_ext, p_pll, p_ref, p_dbg;
    logic [11:0] mult, exp_mult;
    logic [7:0] spi_d, i2c_d;
    logic [15:0] slew;
    logic [1:0] src_exp;
    int miscompares = 0, checks = 0, cyc = 0, seed, refhz;
    int exp_ref;
    logic exp_byp;
    logic [31:0] wv;
    int unsigned refs [4] = '{REF0_HZ, REF1_HZ, REF2_HZ, REF2_HZ};

    ccs_board_model i_ccs_board_model (.sys_clk(sys_clk), .strap_sel(strap),
        .clock_src_strap(strap_pin), .osc_32k_in(osc), .ext_clock_in(ext),
        .pll_output_clock(pll));
    ccs_clock_select i_ccs_clock_select (.sys_clk(sys_clk), .rst(rst),
        .clock_src_strap(strap_pin), .osc_32k_in(osc), .ext_clock_in(ext),
        .pll_output_clock(pll), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .debug_clock_out(dbg), .debug_clock_out_oe(oe),
        .sys_ref_clock(ref_clk), .rtc_clock(rtc), .pll_bypass(byp), .pll_mult(mult),
        .spi_clk_div(spi_d), .i2c_clk_div(i2c_d), .slew_ctrl(slew));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            $display("BAD %s expected %h seen %h", what, e, g);
            miscompares++;
        end
    endtask : chk

    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        chk("apb_pready", 32'h1, {31'h0, pready});
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_oe(input logic v);
        for (int i = 0; i < 60 && oe !== v; i++) @(posedge sys_clk);
    endtask : wait_oe

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
        if (trk) begin
            chk("rtc_clock", {31'h0, p_osc}, {31'h0, rtc});
            chk("sys_ref_clock", {31'h0, strap ? p_ext : p_osc}, {31'h0, ref_clk});
            case (src_exp)
                2'd0: chk("debug_pll", {31'h0, p_pll}, {31'h0, dbg});
                2'd1: chk("debug_ref", {31'h0, p_ref}, {31'h0, dbg});
                2'd2: chk("debug_osc", {31'h0, p_osc}, {31'h0, dbg});
                default: chk("debug_half", {31'h0, ~p_dbg}, {31'h0, dbg});
            endcase
        end
        p_osc = osc;
        p_ext = ext;
        p_pll = pll;
        p_ref = ref_clk;
        p_dbg = dbg;
    end

    task automatic run(input logic s);
        rst <= 1'b1;
        strap <= s;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        exp_mult = 12'h001;
        src_exp = 2'd0;
        repeat (3) @(posedge sys_clk);
        chk("oe_reset", 32'h1, {31'h0, oe});
        chk("bypass_reset", 32'h1, {31'h0, byp});
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_reset", {30'h0, 1'b1, s}, rd);
        apb(1'b0, ADDR_CLKGEN, 32'h0);
        chk("clkgen_reset", 32'h11, rd);
        apb(1'b0, ADDR_SLEW, 32'h0);
        chk("slew_reset", 32'h0, rd);
        wv = 32'($random(seed));
        apb(1'b1, ADDR_SLEW, wv);
        apb(1'b0, ADDR_SLEW, 32'h0);
        chk("slew_rw", {16'h0, wv[15:0]}, rd);
        apb(1'b1, ADDR_STATUS + 18'h4, 32'hffffffff);
        chk("unmapped_err", 32'h1, {31'h0, err});
        apb(1'b1, ADDR_STATUS, 32'hffffffff);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("status_ro", {30'h0, 1'b1, s}, rd);
        exp_ref = s ? REF0_HZ : OSC_HZ;
        exp_byp = 1'b1;
        for (int k = 0; k < 4; k++) begin
            refhz = s ? refs[k] : OSC_HZ;
            wv = {16'h0, 12'($random(seed) & 15), 1'b0, 2'(k), 1'($random(seed))};
            if (wv[15:4] != 0 && longint'(refhz) * wv[15:4] <= PLL_MAX_HZ) begin
                exp_mult = wv[15:4];
                exp_ref = refhz;
                exp_byp = wv[0];
            end
            apb(1'b1, ADDR_CLKGEN, wv);
            repeat (2) @(posedge sys_clk);
            chk("pll_mult", {20'h0, exp_mult}, {20'h0, mult});
            chk("pll_bypass", {31'h0, exp_byp}, {31'h0, byp});
            chk("spi_div", s ? (exp_ref + SPI_HZ - 1) / SPI_HZ : 1, {24'h0, spi_d});
            chk("i2c_div", s ? (exp_ref + I2C_HZ - 1) / I2C_HZ : 1, {24'h0, i2c_d});
        end
        for (int v = 0; v < 4; v++) begin
            apb(1'b1, ADDR_SRC, 32'(v));
            for (int i = 0; i < 15; i++) begin
                apb(1'b0, ADDR_STATUS, 32'h0);
                if (rd[3:2] === 2'(v)) break;
            end
            chk("active_src", 32'(v), {30'h0, rd[3:2]});
            src_exp <= 2'(v);
            @(posedge sys_clk);
            trk <= 1'b1;
            repeat (25) @(posedge sys_clk);
            trk <= 1'b0;
        end
        apb(1'b1, ADDR_ST3, 32'h4);
        wait_oe(1'b0);
        chk("oe_disabled", 32'h0, {31'h0, oe});
        apb(1'b0, ADDR_ST3, 32'h0);
        chk("st3_read", 32'h4, rd);
        apb(1'b1, ADDR_ST3, 32'h0);
        wait_oe(1'b1);
        chk("oe_enabled", 32'h1, {31'h0, oe});
    endtask : run

    initial begin
        seed = 23020;
        rst = 1'b1;
        strap = 1'b0;
        trk = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 18'h0;
        pwdata = 32'h0;
        run(1'b0);
        run(1'b1);
        conclude();
    end
endmodule : tb
